// *** design/pmr_regs_map.svh ***
/*
  Constants for the power-management and identification register bank:
  register select codes, field positions, reset values.
  Assumes it is included by its bare name from the package or modules.
*/
`ifndef PMR_REGS_MAP_SVH
`define PMR_REGS_MAP_SVH

// ****************************************
// register select codes
// ****************************************
`define PMR_SEL_PMC 3'h0
`define PMR_SEL_REV 3'h1
`define PMR_SEL_VARIANT 3'h2
`define PMR_SEL_MAKER 3'h3
`define PMR_SEL_VENDOR 3'h4

// ****************************************
// power management control fields
// ****************************************
`define PMR_POWER_LSB 0
`define PMR_POWER_MSB 1
`define PMR_RSVD_LSB 2
`define PMR_RSVD_MSB 7
`define PMR_ENABLE_BIT 8
`define PMR_SELECT_LSB 9
`define PMR_SELECT_MSB 12
`define PMR_SCALE_LSB 13
`define PMR_SCALE_MSB 14
`define PMR_FLAG_BIT 15

// eeprom setup word bit carrying the initial enable
`define PMR_EE_ENABLE_BIT 6

// ****************************************
// reset values
// ****************************************
`define PMR_POWER_RST 2'h0
`define PMR_SELECT_RST 4'h0
`define PMR_WORD_RST 16'h0000

`endif

// *** design/pmr_pkg.sv ***
/*
  Types shared by the power-management register bank.
  Assumes the map header sits on the include path.
*/
package pmr_pkg;
  `include "pmr_regs_map.svh"

  // power levels, in the order of their two-bit codes
  typedef enum logic [1:0] {
    PMR_D0,
    PMR_D1,
    PMR_D2,
    PMR_D3
  } pmr_power_t;

  // read-only scale code reported beside the data value
  typedef enum logic [1:0] {
    PMR_SCALE_UNKNOWN,
    PMR_SCALE_TENTH,
    PMR_SCALE_HUNDREDTH,
    PMR_SCALE_THOUSANDTH
  } pmr_scale_t;
endpackage

// *** design/pmr_sync2.sv ***
/*
  Two-flop level synchroniser.
  Assumes the input may change at any time relative to clk.
*/
`timescale 1ns/10ps
module pmr_sync2 import pmr_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!nrst) begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// *** design/pmr_regs.sv ***
/*
  Power-management control/status and identification registers of a PCI
  network controller, reached by configuration cycles.
  Assumes: a configuration decoder that issues one-cycle requests with a
  register select, the eeprom loader that pulses once with its words, the
  resume-criteria logic that raises a level on each wake event, and the
  target/master logic that honours the two enables driven here.
*/
//
// Functional notes
// - two-bit power level, D0..D3 codes 0..3
// - nonzero level blocks I/O, memory, mastering
// - wake output only while enable set
// - wake events come from criteria logic
// - eeprom preloads enable; software may overwrite
// - select field chooses reported data quantity
// - read-only two-bit scale code
// - flag set on every wake event
// - write one clears flag, zero ignored
// - bits seven to two read zero
// - read-only eight-bit silicon revision
// - board variant id loaded from eeprom
// - board maker id loaded from eeprom
// - fixed sixteen-bit silicon maker id
// - eeprom setup word bit six gives enable
`timescale 1ns/10ps
`include "pmr_regs_map.svh"
module pmr_regs import pmr_pkg::*; #(
  // arbitrary value, not a real revision
  parameter logic [7:0] SILICON_REV = 8'h5A,
  // arbitrary value, not a real maker code
  parameter logic [15:0] SILICON_MAKER = 16'hC0DE
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [2:0] cfg_sel,
  input wire logic [1:0] cfg_be,
  input wire logic [15:0] cfg_wdata,
  output logic cfg_ack,
  output logic [15:0] cfg_rdata,
  input wire logic ee_load,
  input wire logic [15:0] ee_setup_word,
  input wire logic [15:0] ee_board_variant,
  input wire logic [15:0] ee_board_maker,
  input wire logic resume_event_level,
  input wire logic [1:0] data_scale,
  output logic wake_n,
  output logic target_enable,
  output logic master_enable,
  output logic [3:0] data_select
);

  // ****************************************
  // state
  // ****************************************
  pmr_power_t device_power_level;
  logic resume_report_enable;
  logic resume_event_flag;
  logic init_done;
  logic [15:0] board_variant_identifier;
  logic [15:0] board_maker_identifier;
  logic event_sync;
  logic event_seen;

  // ****************************************
  // helpers
  // ****************************************
  // merge the byte lanes of write data enabled by be over the old value
  function automatic logic [15:0] merge_bytes(
    input logic [15:0] old_val,
    input logic [15:0] new_val,
    input logic [1:0] be
  );
    merge_bytes = {be[1] ? new_val[15:8] : old_val[15:8],
                   be[0] ? new_val[7:0] : old_val[7:0]};
  endfunction

  // ****************************************
  // wake event input
  // ****************************************
  // criteria logic source
  // criteria logic runs from standby power, so the level is resynchronised
  pmr_sync2 u_event_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in(resume_event_level),
    .sync_out(event_sync)
  );

  // rising edge of the synchronised level marks one event
  always_ff @(posedge clk) begin
    if (!nrst) begin
      event_seen <= 1'b0;
    end else begin
      event_seen <= event_sync;
    end
  end

  // ****************************************
  // decode
  // ****************************************
  wire logic wake_pulse;
  wire logic wr_pmc;
  wire logic rd_pmc;
  wire logic [15:0] pmc_merged;
  wire logic [15:0] pmc_read;
  wire logic flag_clear;
  logic [15:0] next_rdata;

  assign wake_pulse = event_sync & ~event_seen;
  assign wr_pmc = cfg_req & cfg_we & (cfg_sel == `PMR_SEL_PMC);
  assign rd_pmc = cfg_req & ~cfg_we & (cfg_sel == `PMR_SEL_PMC);
  assign pmc_merged = merge_bytes(pmc_read, cfg_wdata, cfg_be);
  assign flag_clear = wr_pmc & cfg_be[1] & cfg_wdata[`PMR_FLAG_BIT];

  assign pmc_read = {resume_event_flag,
                     data_scale,
                     data_select,
                     resume_report_enable,
                     6'h00,
                     device_power_level};

  // read mux; eeprom fields stay zero before the load
  always_comb begin
    next_rdata = 16'h0000;
    unique case (cfg_sel)
      `PMR_SEL_PMC: next_rdata = pmc_read;
      `PMR_SEL_REV: next_rdata = {8'h00, SILICON_REV};
      `PMR_SEL_VARIANT: next_rdata = board_variant_identifier;
      `PMR_SEL_MAKER: next_rdata = board_maker_identifier;
      `PMR_SEL_VENDOR: next_rdata = SILICON_MAKER;
      default: next_rdata = 16'h0000;
    endcase
  end

  // ****************************************
  // configuration answer
  // ****************************************
  // ack in every level
  // no term of the power level gates this path, so D3 can be left
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_ack <= 1'b0;
      cfg_rdata <= `PMR_WORD_RST;
    end else begin
      cfg_ack <= cfg_req;
      cfg_rdata <= (cfg_req & ~cfg_we) ? next_rdata : `PMR_WORD_RST;
    end
  end

  // ****************************************
  // control fields
  // ****************************************
  // power level store
  always_ff @(posedge clk) begin
    if (!nrst) begin
      device_power_level <= PMR_D0;
      data_select <= `PMR_SELECT_RST;
    end else if (wr_pmc) begin
      device_power_level <= pmr_power_t'(pmc_merged[`PMR_POWER_MSB:`PMR_POWER_LSB]);
      data_select <= pmc_merged[`PMR_SELECT_MSB:`PMR_SELECT_LSB];
    end
  end

  // setup word bit
  // writes before the load are dropped, the load would override them anyway
  always_ff @(posedge clk) begin
    if (!nrst) begin
      resume_report_enable <= 1'b0;
    end else if (ee_load) begin
      resume_report_enable <= ee_setup_word[`PMR_EE_ENABLE_BIT];
    end else if (wr_pmc && init_done) begin
      resume_report_enable <= pmc_merged[`PMR_ENABLE_BIT];
    end
  end

  // flag set always
  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk) begin
    if (!nrst) begin
      resume_event_flag <= 1'b0;
    end else if (wake_pulse) begin
      resume_event_flag <= 1'b1;
    end else if (flag_clear) begin
      resume_event_flag <= 1'b0;
    end
  end

  // ****************************************
  // eeprom loaded identifiers
  // ****************************************
  // capture at load
  always_ff @(posedge clk) begin
    if (!nrst) begin
      init_done <= 1'b0;
      board_variant_identifier <= `PMR_WORD_RST;
      board_maker_identifier <= `PMR_WORD_RST;
    end else if (ee_load) begin
      init_done <= 1'b1;
      board_variant_identifier <= ee_board_variant;
      board_maker_identifier <= ee_board_maker;
    end
  end

  // ****************************************
  // outputs to the rest of the device
  // ****************************************
  wire logic in_d0;
  assign in_d0 = (device_power_level == PMR_D0);

  // wake gated by enable
  // wake is a level like the pci pme line: held until flag or enable drops
  always_ff @(posedge clk) begin
    if (!nrst) begin
      target_enable <= 1'b0;
      master_enable <= 1'b0;
      wake_n <= 1'b1;
    end else begin
      target_enable <= in_d0;
      master_enable <= in_d0;
      wake_n <= ~(resume_event_flag & resume_report_enable);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_power_store;
    wr_pmc && cfg_be[0] |=> device_power_level == $past(cfg_wdata[1:0]);
  endproperty
  a_power_store: assert property (p_power_store)
    else $error("power level not stored");

  property p_gate_off;
    device_power_level != PMR_D0 |=> !target_enable && !master_enable;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("target or master active outside D0");

  property p_wake_gate;
    !resume_report_enable |=> wake_n;
  endproperty
  a_wake_gate: assert property (p_wake_gate)
    else $error("wake driven while disabled");

  property p_event_flag;
    event_sync && !event_seen |=> resume_event_flag;
  endproperty
  a_event_flag: assert property (p_event_flag)
    else $error("wake event did not set flag");

  property p_wake_follow;
    wake_pulse && resume_report_enable && !ee_load && !wr_pmc |=> ##1 !wake_n;
  endproperty
  a_wake_follow: assert property (p_wake_follow)
    else $error("enabled event did not reach wake output");

  property p_preload;
    ee_load |=> resume_report_enable == $past(ee_setup_word[6]) && init_done;
  endproperty
  a_preload: assert property (p_preload)
    else $error("enable not preloaded from setup word");

  property p_sw_enable;
    wr_pmc && cfg_be[1] && init_done && !ee_load
      |=> resume_report_enable == $past(cfg_wdata[8]);
  endproperty
  a_sw_enable: assert property (p_sw_enable)
    else $error("software write of enable lost");

  property p_select;
    wr_pmc && cfg_be[1] |=> data_select == $past(cfg_wdata[12:9]);
  endproperty
  a_select: assert property (p_select)
    else $error("select field not stored");

  property p_scale;
    rd_pmc |=> cfg_rdata[14:13] == $past(data_scale) && cfg_rdata[7:2] == 6'h00;
  endproperty
  a_scale: assert property (p_scale)
    else $error("scale or reserved bits wrong on read");

  property p_zero_write;
    resume_event_flag && wr_pmc && !cfg_wdata[15] |=> resume_event_flag;
  endproperty
  a_zero_write: assert property (p_zero_write)
    else $error("writing zero changed flag");

  property p_rsvd;
    rd_pmc ##1 cfg_ack |-> cfg_rdata[7:2] == 6'h00;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits not zero");

  property p_rev;
    cfg_req && !cfg_we && cfg_sel == `PMR_SEL_REV |=> cfg_rdata == {8'h00, SILICON_REV};
  endproperty
  a_rev: assert property (p_rev)
    else $error("revision read wrong");

  property p_maker_fixed;
    cfg_req && !cfg_we && cfg_sel == `PMR_SEL_VENDOR |=> cfg_rdata == SILICON_MAKER;
  endproperty
  a_maker_fixed: assert property (p_maker_fixed)
    else $error("maker id read wrong");

  property p_unloaded;
    !init_done && !ee_load && cfg_req && !cfg_we && cfg_sel == `PMR_SEL_VARIANT
      |=> cfg_rdata == 16'h0000;
  endproperty
  a_unloaded: assert property (p_unloaded)
    else $error("variant id nonzero before load");

  property p_loaded;
    ee_load ##1 !ee_load ##1 (cfg_req && !cfg_we && cfg_sel == `PMR_SEL_MAKER)
      |=> cfg_rdata == $past(ee_board_maker, 3);
  endproperty
  a_loaded: assert property (p_loaded)
    else $error("maker id not loaded");

  property p_ack;
    cfg_req |=> cfg_ack ##1 !cfg_ack || $past(cfg_req);
  endproperty
  a_ack: assert property (p_ack)
    else $error("configuration access not answered");

  c_enter_d3: cover property (wr_pmc && cfg_be[0] && cfg_wdata[1:0] == 2'h3);
  c_wake_out: cover property (!wake_n);
  c_set_clear: cover property (wake_pulse && flag_clear);
  c_load: cover property (ee_load);

endmodule

// *** tb/pmr_host_model.sv ***
/*
  Host-bridge model: issues configuration reads and writes to the bank.
  Assumes clk comes from the bench and the bank answers one cycle after
  taking a request.
*/
`timescale 1ns/10ps
module pmr_host_model (
  input wire logic clk,
  output logic cfg_req,
  output logic cfg_we,
  output logic [2:0] cfg_sel,
  output logic [1:0] cfg_be,
  output logic [15:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic [15:0] cfg_rdata
);
  // ****************************************
  // idle bus at time zero
  // ****************************************
  initial begin
    cfg_req = 1'b0;
    cfg_we = 1'b0;
    cfg_sel = 3'h0;
    cfg_be = 2'h0;
    cfg_wdata = 16'h0000;
  end

  // one access: a single-cycle request, answer looked at one cycle later
  // write data goes out exactly as software gives it
  task automatic access(input logic we, input logic [2:0] sel, input logic [1:0] be,
      input logic [15:0] wdata, output logic [15:0] rdata, output logic acked);
    @(negedge clk);
    cfg_req = 1'b1;
    cfg_we = we;
    cfg_sel = sel;
    cfg_be = be;
    cfg_wdata = wdata;
    @(negedge clk);
    // the answer stands for this one cycle only, so take it before letting go
    acked = (cfg_ack === 1'b1);
    rdata = cfg_rdata;
    cfg_req = 1'b0;
    cfg_we = ~we;
    cfg_be = ~be;
    cfg_wdata = ~wdata; // released data must not look valid
  endtask
endmodule

// *** tb/pmr_regs_bench.sv ***
/*
  Self-checking bench for the power-management register bank.
  Assumes the package and map header are compiled before this file.
*/
`timescale 1ns/10ps
`include "pmr_regs_map.svh"
module pmr_regs_bench import pmr_pkg::*; ();
  logic clk = 1'b0;
  logic nrst;
  logic cfg_req, cfg_we, cfg_ack;
  logic [2:0] cfg_sel;
  logic [1:0] cfg_be;
  logic [15:0] cfg_wdata, cfg_rdata;
  logic ee_load, resume_event_level;
  logic [15:0] ee_setup_word, ee_board_variant, ee_board_maker;
  logic [1:0] data_scale;
  logic wake_n, target_enable, master_enable;
  logic [3:0] data_select;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;

  // ****************************************
  // clock, design and host
  // ****************************************
  always #5 clk = ~clk;

  pmr_regs u_dut (.clk(clk), .nrst(nrst), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_sel(cfg_sel), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .ee_load(ee_load), .ee_setup_word(ee_setup_word),
    .ee_board_variant(ee_board_variant), .ee_board_maker(ee_board_maker),
    .resume_event_level(resume_event_level), .data_scale(data_scale),
    .wake_n(wake_n), .target_enable(target_enable), .master_enable(master_enable),
    .data_select(data_select));

  pmr_host_model u_host (.clk(clk), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_sel(cfg_sel), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata));

  // ****************************************
  // checking helpers
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rd(input logic [2:0] sel, input logic [15:0] exp);
    logic [15:0] d;
    logic a;
    u_host.access(1'b0, sel, 2'h3, 16'h0000, d, a);
    chk("cfg_ack", 16'h0001, {15'h0000, a});
    chk("cfg_rdata", exp, d);
  endtask

  task automatic wr(input logic [2:0] sel, input logic [1:0] be, input logic [15:0] wd);
    logic [15:0] d;
    logic a;
    u_host.access(1'b1, sel, be, wd, d, a);
    chk("cfg_ack", 16'h0001, {15'h0000, a});
    chk("cfg_rdata", 16'h0000, d);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard: the sequence needs about eighty cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      final_report();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    nrst = 1'b0;
    ee_load = 1'b0;
    ee_setup_word = 16'h0000;
    ee_board_variant = 16'h0000;
    ee_board_maker = 16'h0000;
    resume_event_level = 1'b0;
    data_scale = 2'h0;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk("target_enable", 16'h0001, {15'h0000, target_enable});
    rd(`PMR_SEL_PMC, 16'h0000);
    rd(`PMR_SEL_VARIANT, 16'h0000);
    rd(`PMR_SEL_MAKER, 16'h0000);
    rd(`PMR_SEL_REV, 16'h005A);
    rd(`PMR_SEL_VENDOR, 16'hC0DE);
    rd(3'h5, 16'h0000);
    wr(`PMR_SEL_PMC, 2'h3, 16'h0100);
    rd(`PMR_SEL_PMC, 16'h0000);
    // eeprom words arrive with one strobe, then the loader lets go
    @(negedge clk);
    ee_setup_word = 16'h0040;
    ee_board_variant = 16'h1234;
    ee_board_maker = 16'hABCD;
    ee_load = 1'b1;
    @(negedge clk);
    ee_load = 1'b0;
    ee_setup_word = 16'hFFBF;
    ee_board_variant = 16'hEDCB;
    ee_board_maker = 16'h5432;
    rd(`PMR_SEL_MAKER, 16'hABCD);
    rd(`PMR_SEL_VARIANT, 16'h1234);
    rd(`PMR_SEL_PMC, 16'h0100);
    wr(`PMR_SEL_VARIANT, 2'h3, 16'hFFFF);
    rd(`PMR_SEL_VARIANT, 16'h1234);
    // every level and scale, select values 0, 5, 10, 15; reserved bits written as zero, as software must
    for (int i = 0; i < 4; i++) begin
      data_scale = 2'(i);
      wr(`PMR_SEL_PMC, 2'h3, {3'b011, 4'(i * 5), 1'b1, 6'h00, 2'(i)});
      rd(`PMR_SEL_PMC, {1'b0, 2'(i), 4'(i * 5), 1'b1, 6'h00, 2'(i)});
      chk("target_enable", {15'h0000, i == 0}, {15'h0000, target_enable});
      chk("master_enable", {15'h0000, i == 0}, {15'h0000, master_enable});
      chk("data_select", 16'(i * 5), {12'h000, data_select});
    end
    data_scale = 2'h0;
    wr(`PMR_SEL_PMC, 2'h3, 16'h0100);
    rd(`PMR_SEL_PMC, 16'h0100);
    // wake event with the enable set
    resume_event_level = 1'b1;
    repeat (6) @(negedge clk);
    chk("wake_n", 16'h0000, {15'h0000, wake_n});
    rd(`PMR_SEL_PMC, 16'h8100);
    resume_event_level = 1'b0;
    wr(`PMR_SEL_PMC, 2'h3, 16'h0100);
    rd(`PMR_SEL_PMC, 16'h8100);
    wr(`PMR_SEL_PMC, 2'h1, 16'h8100);
    rd(`PMR_SEL_PMC, 16'h8100);
    wr(`PMR_SEL_PMC, 2'h3, 16'h8100);
    rd(`PMR_SEL_PMC, 16'h0100);
    chk("wake_n", 16'h0001, {15'h0000, wake_n});
    // event with the enable clear: flag only, no wake output
    wr(`PMR_SEL_PMC, 2'h3, 16'h0000);
    resume_event_level = 1'b1;
    repeat (6) @(negedge clk);
    chk("wake_n", 16'h0001, {15'h0000, wake_n});
    rd(`PMR_SEL_PMC, 16'h8000);
    final_report();
  end
endmodule
